// File: sce_top.sv
// sent output configuration word, error mask and masked error status with bus access
//
// Contract
// [RULE1] tick equals field times 16 MHz period
// [RULE2] tick field zero behaves as one
// [RULE3] host should pick tick of 0.5 us or more
// [RULE4] customer field stored and read back only
// [RULE5] slot mark pulse after address pulse
// [RULE6] code 000 off, 001 back-to-back frames
// [RULE7] code 010 inserts pause pulse
// [RULE8] code 011 triggered, capture near scn end
// [RULE9] code 100 triggered, capture on trigger fall
// [RULE10] 101 addressable, 110 sequential, 111 long
// [RULE11] set mask bit blocks its error flag
// [RULE12] mask 23..12 map to extended flags 11..0
// [RULE13] mask 10..0 map to primary flags 10..0
// [RULE14] host writes zero to mask bit 11
// [RULE15] mask has no volatile working copy
// [RULE16] mask applied when flag would set
`timescale 1ns/1ps
`default_nettype none
module sce_top
	import sce_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic [REG_W-1:0] err_evt_i,
	input wire logic trig_pin_i,
	input wire logic scn_end_i,
	input wire logic addr_pulse_i,
	input wire logic [3:0] slot_addr_i,
	output logic tick_o,
	output logic sent_enable_o,
	output logic stream_o,
	output logic pause_enable_o,
	output logic triggered_variant_o,
	output logic addressable_variant_o,
	output logic sequential_slot_variant_o,
	output logic long_seq_o,
	output logic frame_start_o,
	output logic data_capture_o,
	output logic slot_mark_o,
	output logic [PRI_W-1:0] pri_err_o,
	output logic [EXT_W-1:0] ext_err_o,
	output logic general_err_o,
	output logic irq_o
);
	function automatic sce_sel_t reg_sel(input logic [ADDR_W-1:0] a);
		sce_sel_t s;
		s = '0;
		if (a == CFG_ADDR) begin
			s.cfg = 1'b1;
		end else if (a == MASK_ADDR) begin
			s.mask = 1'b1;
		end else if (a == PRI_ERR_ADDR) begin
			s.pri = 1'b1;
		end else if (a == EXT_ERR_ADDR) begin
			s.ext = 1'b1;
		end else if (a == IRQ_STAT_ADDR) begin
			s.stat = 1'b1;
		end else if (a == IRQ_EN_ADDR) begin
			s.en = 1'b1;
		end else if (a == IRQ_CLR_ADDR) begin
			s.clr = 1'b1;
		end
		return s;
	endfunction : reg_sel

	////////////////////////////////////////////////////////////////////////
	// state
	sce_cfg_t cfg_r;
	logic [REG_W-1:0] mask_r;
	logic [PRI_W-1:0] pri_r;
	logic [EXT_W-1:0] ext_r;
	logic [IRQ_W-1:0] irq_stat_r;
	logic [IRQ_W-1:0] irq_en_r;
	logic aw_got_r;
	logic w_got_r;
	logic [ADDR_W-1:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic trig_s1_r;
	logic trig_s2_r;
	logic trig_s3_r;
	logic trig_lvl_r;
	logic trig_prev_r;
	sce_slot_t slot_st_r;
	logic [3:0] slot_cnt_r;
	logic slot_done_r;

	////////////////////////////////////////////////////////////////////////
	// bus decode
	wire aw_take = s_axi_awvalid_i && s_axi_awready_o;
	wire w_take = s_axi_wvalid_i && s_axi_wready_o;
	wire aw_have = aw_got_r || aw_take;
	wire w_have = w_got_r || w_take;
	wire wr_fire = aw_have && w_have;
	wire [ADDR_W-1:0] wr_addr = aw_take ? s_axi_awaddr_i : awaddr_r;
	wire [31:0] wr_data = w_take ? s_axi_wdata_i : wdata_r;
	wire [3:0] wr_strb = w_take ? s_axi_wstrb_i : wstrb_r;
	wire [REG_W-1:0] wr_bm = {{8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
	wire [REG_W-1:0] wr_val = wr_data[REG_W-1:0] & wr_bm;
	wire sce_sel_t wsel = reg_sel(wr_addr);
	wire wr_hit = wr_fire && (wsel != '0);
	wire b_done = s_axi_bvalid_o && s_axi_bready_i;
	wire bvalid_nxt = wr_fire || (s_axi_bvalid_o && !s_axi_bready_i);
	wire aw_got_nxt = aw_have && !wr_fire;
	wire w_got_nxt = w_have && !wr_fire;
	wire ar_take = s_axi_arvalid_i && s_axi_arready_o;
	wire rvalid_nxt = ar_take || (s_axi_rvalid_o && !s_axi_rready_i);
	wire sce_sel_t rsel = reg_sel(s_axi_araddr_i);

	// write effects: config and mask merged under their byte lanes, clears and enable take lane-masked data
	wire [REG_W-1:0] cfg_merge = (cfg_r & ~wr_bm) | wr_val;
	wire [REG_W-1:0] mask_merge = (mask_r & ~wr_bm) | wr_val;
	wire cfg_wr = wr_fire && wsel.cfg;
	wire mask_wr = wr_fire && wsel.mask;
	wire [PRI_W-1:0] pri_clr = (wr_fire && wsel.pri) ? wr_val[PRI_W-1:0] : '0;
	wire [EXT_W-1:0] ext_clr = (wr_fire && wsel.ext) ? wr_val[EXT_W-1:0] : '0;
	wire [IRQ_W-1:0] irq_clr = (wr_fire && wsel.clr) ? wr_val[IRQ_W-1:0] : '0;

	////////////////////////////////////////////////////////////////////////
	// masked error flags
	// the mask gates the set term, so a masked condition never lands in status
	wire [REG_W-1:0] err_set = err_evt_i & ~mask_r; // [RULE11] [RULE16]
	wire [PRI_W-1:0] pri_set = err_set[PRI_W-1:0]; // [RULE13]
	wire [EXT_W-1:0] ext_set = err_set[EXT_LSB +: EXT_W]; // [RULE12]
	wire [PRI_W-1:0] pri_nxt = (pri_r & ~pri_clr) | pri_set;
	wire [EXT_W-1:0] ext_nxt = (ext_r & ~ext_clr) | ext_set;

	////////////////////////////////////////////////////////////////////////
	// trigger pin and mode actions
	wire trig_rise = trig_lvl_r && !trig_prev_r;
	wire trig_fall = !trig_lvl_r && trig_prev_r;
	wire trig_scn_mode = (cfg_r.mode == MODE_TRIG_SCN);
	wire trig_fall_mode = (cfg_r.mode == MODE_TRIG_FALL);
	wire seq_mode = (cfg_r.mode == MODE_SEQ) || (cfg_r.mode == MODE_SEQ_LONG);
	wire start_nxt = (trig_scn_mode && trig_rise) || (trig_fall_mode && trig_fall);
	wire cap_nxt = (trig_scn_mode && scn_end_i) || (trig_fall_mode && trig_fall); // [RULE8] [RULE9]
	wire slot_go = addr_pulse_i && seq_mode && cfg_r.sm && (slot_addr_i != 4'h0); // [RULE5]
	wire slot_tick = (slot_st_r == SLOT_HIGH) && tick_o;
	wire slot_end = slot_tick && (slot_cnt_r == 4'h1);

	// reserved mask bit 11 has no flag behind it, so it raises no error interrupt
	wire [IRQ_W-1:0] irq_evt = {slot_done_r, cap_nxt, |{pri_set, ext_set}}; // [RULE11]
	wire [IRQ_W-1:0] irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_evt;
	wire [IRQ_W-1:0] irq_en_nxt = (wr_fire && wsel.en) ? wr_val[IRQ_W-1:0] : irq_en_r;

	// read mux; the clear register is write only and reads zero
	wire [REG_W-1:0] rd_val = rsel.cfg ? REG_W'(cfg_r) :
		rsel.mask ? mask_r :
		rsel.pri ? REG_W'(pri_r) :
		rsel.ext ? REG_W'(ext_r) :
		rsel.stat ? REG_W'(irq_stat_r) :
		rsel.en ? REG_W'(irq_en_r) : '0;

	sce_tick_gen u_tick (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.tick_count_i(cfg_r.tick),
		.tick_o(tick_o)
	);

	////////////////////////////////////////////////////////////////////////
	// bus slave
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= '0;
			wstrb_r <= '0;
			s_axi_awready_o <= 1'b0;
			s_axi_wready_o <= 1'b0;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= RESP_OKAY;
		end else begin
			aw_got_r <= aw_got_nxt;
			w_got_r <= w_got_nxt;
			if (aw_take) begin
				awaddr_r <= s_axi_awaddr_i;
			end
			if (w_take) begin
				wdata_r <= s_axi_wdata_i;
				wstrb_r <= s_axi_wstrb_i;
			end
			s_axi_awready_o <= !aw_got_nxt && !bvalid_nxt;
			s_axi_wready_o <= !w_got_nxt && !bvalid_nxt;
			s_axi_bvalid_o <= bvalid_nxt;
			if (wr_fire) begin
				s_axi_bresp_o <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= '0;
			s_axi_rresp_o <= RESP_OKAY;
		end else begin
			s_axi_arready_o <= !rvalid_nxt;
			s_axi_rvalid_o <= rvalid_nxt;
			if (ar_take) begin
				s_axi_rdata_o <= {8'h00, rd_val};
				s_axi_rresp_o <= (rsel != '0) ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registers
	// the mask lives only here; nothing else holds or shadows it
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			cfg_r <= sce_cfg_t'(CFG_RST);
			mask_r <= MASK_RST;
		end else begin
			if (cfg_wr) begin
				cfg_r <= sce_cfg_t'(cfg_merge & ~(REG_W'(1) << CFG_RSVD_BIT)); // [RULE4]
			end
			if (mask_wr) begin
				mask_r <= mask_merge; // [RULE15]
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			pri_r <= '0;
			ext_r <= '0;
			irq_stat_r <= '0;
			irq_en_r <= '0;
			pri_err_o <= '0;
			ext_err_o <= '0;
			general_err_o <= 1'b0;
			irq_o <= 1'b0;
		end else begin
			pri_r <= pri_nxt; // [RULE13]
			ext_r <= ext_nxt; // [RULE12]
			pri_err_o <= pri_nxt;
			ext_err_o <= ext_nxt;
			general_err_o <= |{pri_nxt, ext_nxt}; // [RULE11]
			irq_stat_r <= irq_stat_nxt;
			irq_en_r <= irq_en_nxt;
			irq_o <= |(irq_stat_nxt & irq_en_nxt);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// trigger pin: three stages, a change counts once stages two and three agree
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			trig_s1_r <= 1'b0;
			trig_s2_r <= 1'b0;
			trig_s3_r <= 1'b0;
			trig_lvl_r <= 1'b0;
			trig_prev_r <= 1'b0;
		end else begin
			trig_s1_r <= trig_pin_i;
			trig_s2_r <= trig_s1_r;
			trig_s3_r <= trig_s2_r;
			if (trig_s2_r == trig_s3_r) begin
				trig_lvl_r <= trig_s3_r;
			end
			trig_prev_r <= trig_lvl_r;
		end
	end

	// mode outputs follow the stored word one cycle later
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			sent_enable_o <= 1'b0;
			stream_o <= 1'b0;
			pause_enable_o <= 1'b0;
			triggered_variant_o <= 1'b0;
			addressable_variant_o <= 1'b0;
			sequential_slot_variant_o <= 1'b0;
			long_seq_o <= 1'b0;
			frame_start_o <= 1'b0;
			data_capture_o <= 1'b0;
		end else begin
			sent_enable_o <= (cfg_r.mode != MODE_OFF); // [RULE6]
			stream_o <= (cfg_r.mode == MODE_STREAM) || (cfg_r.mode == MODE_PAUSE); // [RULE6]
			pause_enable_o <= (cfg_r.mode == MODE_PAUSE); // [RULE7]
			triggered_variant_o <= trig_scn_mode || trig_fall_mode; // [RULE8] [RULE9]
			addressable_variant_o <= (cfg_r.mode == MODE_ADDR); // [RULE10]
			sequential_slot_variant_o <= seq_mode; // [RULE10]
			long_seq_o <= (cfg_r.mode == MODE_SEQ_LONG); // [RULE10]
			frame_start_o <= start_nxt;
			data_capture_o <= cap_nxt; // [RULE8] [RULE9]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// slot mark: high for address times unit ticks; address zero gives no pulse
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			slot_st_r <= SLOT_IDLE;
			slot_cnt_r <= '0;
			slot_mark_o <= 1'b0;
			slot_done_r <= 1'b0;
		end else begin
			slot_done_r <= slot_end;
			case (slot_st_r)
				SLOT_IDLE: begin
					if (slot_go) begin
						slot_st_r <= SLOT_HIGH;
						slot_cnt_r <= 4'(slot_addr_i * SLOT_UNIT_TICKS); // [RULE5]
						slot_mark_o <= 1'b1;
					end
				end
				SLOT_HIGH: begin
					if (slot_end) begin
						slot_st_r <= SLOT_IDLE;
						slot_mark_o <= 1'b0;
					end else if (slot_tick) begin
						slot_cnt_r <= slot_cnt_r - 4'h1;
					end
				end
				default: begin
					slot_st_r <= SLOT_IDLE;
					slot_mark_o <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	// check helper: cycles since the last tick; a config write voids the running gap
	logic [7:0] tick_gap_r;
	logic tick_clean_r;
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			tick_gap_r <= 8'h00;
			tick_clean_r <= 1'b0;
		end else begin
			if (tick_o) begin
				tick_gap_r <= 8'h01;
			end else if (tick_gap_r != 8'hFF) begin
				tick_gap_r <= tick_gap_r + 8'h01;
			end
			tick_clean_r <= (tick_o || tick_clean_r) && !cfg_wr;
		end
	end

	property p_tick_min;
		tick_clean_r && (cfg_r.tick <= 7'h01) |->
			(tick_gap_r <= 8'h10) && (!tick_o || (tick_gap_r >= 8'h0F));
	endproperty
	a_tick_min: assert property (p_tick_min) else $error("zero or one tick not 15-16 cycles"); // [RULE2]

	property p_tick_eight;
		tick_clean_r && (cfg_r.tick == 7'h08) |->
			(tick_gap_r <= 8'h7D) && (!tick_o || (tick_gap_r == 8'h7D));
	endproperty
	a_tick_eight: assert property (p_tick_eight) else $error("tick code 8 not 125 cycles"); // [RULE1]

	property p_cust_hold;
		!cfg_wr |=> $stable(cfg_r.customer);
	endproperty
	a_cust_hold: assert property (p_cust_hold) else $error("customer field changed unwritten"); // [RULE4]

	property p_off;
		(cfg_r.mode == MODE_OFF) |=> !sent_enable_o && !stream_o;
	endproperty
	a_off: assert property (p_off) else $error("output enabled in mode off"); // [RULE6]

	property p_pause;
		(cfg_r.mode == MODE_PAUSE) |=> pause_enable_o && stream_o;
	endproperty
	a_pause: assert property (p_pause) else $error("pause mode without pause pulse"); // [RULE7]

	property p_fall_cap;
		trig_fall_mode && trig_fall |=> data_capture_o && frame_start_o;
	endproperty
	a_fall_cap: assert property (p_fall_cap) else $error("no capture on trigger fall"); // [RULE9]

	property p_scn_cap;
		trig_scn_mode && scn_end_i |=> data_capture_o;
	endproperty
	a_scn_cap: assert property (p_scn_cap) else $error("no capture at scn end"); // [RULE8]

	property p_seq;
		(cfg_r.mode == MODE_SEQ) |=> sequential_slot_variant_o && !addressable_variant_o;
	endproperty
	a_seq: assert property (p_seq) else $error("sequential mode not selected"); // [RULE10]

	property p_slot_cause;
		$rose(slot_mark_o) |-> $past(addr_pulse_i) && $past(cfg_r.sm);
	endproperty
	a_slot_cause: assert property (p_slot_cause) else $error("slot mark without cause"); // [RULE5]

	property p_mask_block;
		##1 ((({ext_err_o, 1'b0, pri_err_o} & ~$past({ext_err_o, 1'b0, pri_err_o}))
			& $past(mask_r)) == '0);
	endproperty
	a_mask_block: assert property (p_mask_block) else $error("masked flag was set"); // [RULE11]

	property p_ext_map;
		err_evt_i[23] && !mask_r[23] |=> ext_err_o[11] && general_err_o;
	endproperty
	a_ext_map: assert property (p_ext_map) else $error("mask 23 not on ext flag 11"); // [RULE12]

	property p_pri_map;
		err_evt_i[0] && !mask_r[0] |=> pri_err_o[0] && general_err_o;
	endproperty
	a_pri_map: assert property (p_pri_map) else $error("mask 0 not on pri flag 0"); // [RULE13]

	c_write: cover property (wr_fire && wsel.cfg);
	c_slot: cover property (slot_done_r);
	c_irq: cover property ($rose(irq_o));
	c_trig: cover property (trig_fall_mode && trig_fall);
endmodule : sce_top
`default_nettype wire

// File: sce_pkg.sv
// constants, types and register map of the sent configuration and error mask bank
`default_nettype none
package sce_pkg;
	// clock and tick timing
	localparam int unsigned CLK_PERIOD_PS = 4_000;
	localparam int unsigned REF_PERIOD_PS = 62_500;
	localparam int unsigned MIN_TICK_PS = 500_000;
	localparam int unsigned ACC_W = 17;
	localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(CLK_PERIOD_PS);
	localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(REF_PERIOD_PS);
	localparam logic [3:0] SLOT_UNIT_TICKS = 4'h1;

	// register indices and byte addresses
	localparam int unsigned ADDR_W = 12;
	localparam logic [ADDR_W-1:0] CFG_IDX = 12'h317;
	localparam logic [ADDR_W-1:0] MASK_IDX = 12'h318;
	localparam logic [ADDR_W-1:0] CFG_ADDR = ADDR_W'({CFG_IDX, 2'b00});
	localparam logic [ADDR_W-1:0] MASK_ADDR = ADDR_W'({MASK_IDX, 2'b00});
	localparam logic [ADDR_W-1:0] PRI_ERR_ADDR = 12'hC80;
	localparam logic [ADDR_W-1:0] EXT_ERR_ADDR = 12'hC84;
	localparam logic [ADDR_W-1:0] IRQ_STAT_ADDR = 12'hC88;
	localparam logic [ADDR_W-1:0] IRQ_EN_ADDR = 12'hC8C;
	localparam logic [ADDR_W-1:0] IRQ_CLR_ADDR = 12'hC90;

	// field layout
	localparam int unsigned REG_W = 24;
	localparam int unsigned CFG_RSVD_BIT = 11;
	localparam int unsigned MASK_RSVD_BIT = 11;
	localparam int unsigned EXT_LSB = 12;
	localparam int unsigned EXT_W = 12;
	localparam int unsigned PRI_W = 11;
	localparam int unsigned IRQ_W = 3;
	localparam int unsigned IRQ_ERR_BIT = 0;
	localparam int unsigned IRQ_CAP_BIT = 1;
	localparam int unsigned IRQ_SLOT_BIT = 2;

	// reset values
	localparam logic [REG_W-1:0] CFG_RST = 24'h00_0000;
	localparam logic [REG_W-1:0] MASK_RST = 24'h00_0000;

	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		MODE_OFF = 3'h0,
		MODE_STREAM = 3'h1,
		MODE_PAUSE = 3'h2,
		MODE_TRIG_SCN = 3'h3,
		MODE_TRIG_FALL = 3'h4,
		MODE_ADDR = 3'h5,
		MODE_SEQ = 3'h6,
		MODE_SEQ_LONG = 3'h7
	} sce_mode_t;

	typedef struct packed {
		logic [11:0] customer;
		logic rsvd;
		logic [6:0] tick;
		logic sm;
		sce_mode_t mode;
	} sce_cfg_t;

	typedef enum logic [1:0] {
		SLOT_IDLE = 2'b01,
		SLOT_HIGH = 2'b10
	} sce_slot_t;

	// one-hot register select, order of the read mux
	typedef struct packed {
		logic cfg;
		logic mask;
		logic pri;
		logic ext;
		logic stat;
		logic en;
		logic clr;
	} sce_sel_t;
endpackage : sce_pkg
`default_nettype wire

// File: sce_tick_gen.sv
// tick generator: 16 MHz reference phase from the core clock, divided by the tick field
`timescale 1ns/1ps
`default_nettype none
module sce_tick_gen
	import sce_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic [6:0] tick_count_i,
	output logic tick_o
);
	logic [ACC_W-1:0] acc_r;
	logic [6:0] ref_cnt_r;
	logic [ACC_W-1:0] acc_sum;
	logic ref_pulse;
	logic [6:0] tick_eff;
	logic ref_last;

	// 250/16 is not whole, so the reference edge jitters between 15 and 16 cycles
	assign acc_sum = acc_r + ACC_STEP;
	assign ref_pulse = (acc_sum >= ACC_WRAP);
	assign tick_eff = (tick_count_i == 7'h00) ? 7'h01 : tick_count_i; // [RULE2]
	assign ref_last = (ref_cnt_r >= tick_eff - 7'h01);

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			acc_r <= '0;
			ref_cnt_r <= '0;
			tick_o <= 1'b0;
		end else begin
			acc_r <= ref_pulse ? acc_sum - ACC_WRAP : acc_sum;
			tick_o <= ref_pulse && ref_last; // [RULE1]
			if (ref_pulse) begin
				ref_cnt_r <= ref_last ? 7'h00 : ref_cnt_r + 7'h01; // [RULE1]
			end
		end
	end
endmodule : sce_tick_gen
`default_nettype wire

// File: sce_rx_model.sv
// far-side model: receiver side that pulses addressing, trigger and nibble events
`timescale 1ns/1ps
`default_nettype none
module sce_rx_model (
	input wire logic mclk_i,
	output logic trig_pin_o,
	output logic scn_end_o,
	output logic addr_pulse_o,
	output logic [3:0] slot_addr_o
);
	initial begin
		trig_pin_o = 1'b0;
		scn_end_o = 1'b0;
		addr_pulse_o = 1'b0;
		slot_addr_o = 4'hF;
	end

	////////////////////////////////////////////////////////////////////////////////
	// one-cycle end-of-status-nibble mark
	task automatic scn_pulse();
		scn_end_o <= 1'b1;
		@(posedge mclk_i);
		scn_end_o <= 1'b0;
	endtask : scn_pulse

	// address valid only with the pulse, inverted after so a stale value is never trusted
	task automatic addr_pulse(input logic [3:0] a);
		slot_addr_o <= a;
		addr_pulse_o <= 1'b1;
		@(posedge mclk_i);
		addr_pulse_o <= 1'b0;
		slot_addr_o <= ~a;
	endtask : addr_pulse

	// trigger level held long enough for the synchroniser
	task automatic trig_set(input logic v);
		trig_pin_o <= v;
		repeat (8) @(posedge mclk_i);
	endtask : trig_set
endmodule : sce_rx_model
`default_nettype wire

// File: sent_config_and_error_mask_bench.sv
// self-checking bench for the sent configuration and error mask bank
`timescale 1ns/1ps
`default_nettype none
module sent_config_and_error_mask_bench
	import sce_pkg::*;
();
	logic mclk_i;
	logic rst_i = 1'b1;
	logic [ADDR_W-1:0] awaddr = 12'h000, araddr = 12'h000;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] wstrb = 4'hF;
	logic [REG_W-1:0] evt = 24'h00_0000;
	logic awready, wready, bvalid, arready, rvalid, tick, en, strm, pau, trv, adv, sqv, lng;
	logic fst, cap, slm, gerr, irq, trg, scn, apl;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [PRI_W-1:0] pri;
	logic [EXT_W-1:0] ext;
	logic [3:0] sadr;
	logic [3:0] pv;
	int n_fail = 0;
	int n_compared = 0;
	logic [1:0] bq[$];
	logic [33:0] rq[$];
	logic [33:0] rx_note;

	assign pv = {tick, slm, cap, fst};

	sce_top uut (
		.mclk_i(mclk_i), .rst_i(rst_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
		.err_evt_i(evt), .trig_pin_i(trg), .scn_end_i(scn), .addr_pulse_i(apl),
		.slot_addr_i(sadr), .tick_o(tick), .sent_enable_o(en), .stream_o(strm),
		.pause_enable_o(pau), .triggered_variant_o(trv), .addressable_variant_o(adv),
		.sequential_slot_variant_o(sqv), .long_seq_o(lng), .frame_start_o(fst),
		.data_capture_o(cap), .slot_mark_o(slm), .pri_err_o(pri), .ext_err_o(ext),
		.general_err_o(gerr), .irq_o(irq)
	);

	sce_rx_model rx (
		.mclk_i(mclk_i), .trig_pin_o(trg), .scn_end_o(scn), .addr_pulse_o(apl),
		.slot_addr_o(sadr)
	);

	initial begin
		mclk_i = 1'b0;
		forever #2 mclk_i = ~mclk_i;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : complete_run

	task automatic cmp_bus(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask : cmp_bus

	task automatic cmp_out(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask : cmp_out

	// one bus transfer; expectation noted before the request goes out
	task automatic bus(input bit w, input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] er);
		int n;
		bit done;
		n = 0;
		done = 1'b0;
		if (w) begin
			bq.push_back(er);
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
		end else begin
			rq.push_back({er, d});
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
		end
		while (!done && n < 100) begin
			@(posedge mclk_i);
			n++;
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
			done = w ? (bvalid === 1'b1) : (rvalid === 1'b1);
		end
		bready <= 1'b0;
		rready <= 1'b0;
		@(posedge mclk_i);
		if (!done) n_fail++;
	endtask : bus

	task automatic cyc(input int k);
		repeat (k) @(posedge mclk_i);
	endtask : cyc

	// cycles until pv[b] shows v, lim+1 if never
	task automatic wait_bit(input int b, input logic v, input int lim, output int n);
		n = 0;
		while (pv[b] !== v && n <= lim) begin
			@(posedge mclk_i);
			n++;
		end
	endtask : wait_bit

	task automatic evt_pulse(input logic [23:0] v);
		evt <= v;
		@(posedge mclk_i);
		evt <= 24'h00_0000;
		cyc(2);
	endtask : evt_pulse

	function automatic logic [6:0] mode_exp(input logic [2:0] m);
		return {m != 3'h0, m == 3'h1 || m == 3'h2, m == 3'h2, m == 3'h3 || m == 3'h4,
			m == 3'h5, m[2:1] == 2'b11, m == 3'h7};
	endfunction : mode_exp

	////////////////////////////////////////////////////////////////////////////////
	// result watcher: oldest note against each bus answer
	always @(posedge mclk_i) begin
		if (bvalid === 1'b1 && bready && bq.size() > 0) begin
			cmp_bus("write response", {30'h0, bq.pop_front()}, {30'h0, bresp});
		end
		if (rvalid === 1'b1 && rready && rq.size() > 0) begin
			rx_note = rq.pop_front();
			cmp_bus("read response", {30'h0, rx_note[33:32]}, {30'h0, rresp});
			cmp_bus("read data", rx_note[31:0], rdata);
		end
	end

	initial begin
		#300_000;
		n_fail++;
		complete_run();
	end

	initial begin
		int n;
		int g;
		logic [23:0] mk;
		logic [31:0] cw;
		logic [7:0] lb;
		int tk[4] = '{0, 1, 8, 127};
		int lo[4] = '{15, 15, 125, 1984};
		int sp[4] = '{1, 1, 0, 1};
		void'($urandom(86));
		cyc(4);
		rst_i <= 1'b0;
		cyc(2);
		bus(0, CFG_ADDR, 32'h0000_0000, RESP_OKAY);
		bus(0, MASK_ADDR, 32'h0000_0000, RESP_OKAY);
		bus(1, 12'h004, 32'hFFFF_FFFF, RESP_SLVERR);
		bus(0, 12'h004, 32'h0000_0000, RESP_SLVERR);
		bus(0, CFG_ADDR, 32'h0000_0000, RESP_OKAY);
		$display("test reset and map done");
		// reserved bit 11 of the config word is written as one and must read zero
		cw = {8'hFF, 12'($urandom), 1'b1, 7'($urandom_range(127, 8)), 4'($urandom)};
		bus(1, CFG_ADDR, cw, RESP_OKAY);
		bus(0, CFG_ADDR, {8'h00, cw[23:12], 1'b0, cw[10:0]}, RESP_OKAY);
		// lane 0 only: the upper lanes must keep their stored bits
		lb = 8'($urandom);
		wstrb <= 4'h1;
		bus(1, CFG_ADDR, {24'hFF_FFFF, lb}, RESP_OKAY);
		wstrb <= 4'hF;
		bus(0, CFG_ADDR, {8'h00, cw[23:12], 1'b0, cw[10:8], lb}, RESP_OKAY);
		$display("test config readback done");
		for (int m = 0; m < 8; m++) begin
			bus(1, CFG_ADDR, {21'h0, 7'h08, 1'b0, 3'(m)}, RESP_OKAY);
			cyc(2);
			cmp_out("mode outputs", {25'h0, mode_exp(3'(m))},
				{25'h0, en, strm, pau, trv, adv, sqv, lng});
		end
		$display("test mode decode done");
		// codes below 0.5 us only to see the floor; twice synced as a change lands mid-count
		foreach (tk[i]) begin
			bus(1, CFG_ADDR, {21'h0, 7'(tk[i]), 1'b0, 3'h1}, RESP_OKAY);
			repeat (2) begin
				wait_bit(3, 1'b1, 2100, n);
				@(posedge mclk_i);
			end
			wait_bit(3, 1'b1, 2100, g);
			cmp_out("tick gap", 1, 32'(g + 1 >= lo[i] && g + 1 <= lo[i] + sp[i]));
		end
		$display("test tick period done");
		mk = 24'($urandom) & 24'hFF_F7FF;
		bus(1, MASK_ADDR, {8'h00, mk}, RESP_OKAY);
		bus(0, MASK_ADDR, {8'h00, mk}, RESP_OKAY);
		evt_pulse(24'hFF_FFFF);
		cmp_out("primary flags", {21'h0, ~mk[10:0]}, {21'h0, pri});
		cmp_out("extended flags", {20'h0, ~mk[23:12]}, {20'h0, ext});
		cmp_out("general flag", {31'h0, |{~mk[23:12], ~mk[10:0]}}, {31'h0, gerr});
		bus(0, PRI_ERR_ADDR, {21'h0, ~mk[10:0]}, RESP_OKAY);
		bus(1, PRI_ERR_ADDR, 32'h0000_07FF, RESP_OKAY);
		bus(1, EXT_ERR_ADDR, 32'h0000_0FFF, RESP_OKAY);
		bus(1, IRQ_CLR_ADDR, 32'h0000_0007, RESP_OKAY);
		bus(0, EXT_ERR_ADDR, 32'h0000_0000, RESP_OKAY);
		// all masked, then unmasked: nothing may surface afterwards
		bus(1, MASK_ADDR, 32'h00FF_F7FF, RESP_OKAY);
		evt_pulse(24'hFF_FFFF);
		bus(1, MASK_ADDR, 32'h0000_0000, RESP_OKAY);
		cyc(2);
		cmp_out("flags after unmask", 32'h0, {8'h0, pri, ext, gerr});
		bus(0, IRQ_STAT_ADDR, 32'h0000_0000, RESP_OKAY);
		$display("test error mask done");
		bus(1, IRQ_EN_ADDR, 32'h0000_0001, RESP_OKAY);
		evt_pulse(24'h00_0001);
		cmp_out("irq raised", 32'h1, {31'h0, irq});
		bus(1, IRQ_EN_ADDR, 32'h0000_0000, RESP_OKAY);
		cyc(2);
		cmp_out("irq masked", 32'h0, {31'h0, irq});
		bus(0, IRQ_STAT_ADDR, 32'h0000_0001, RESP_OKAY);
		bus(1, IRQ_CLR_ADDR, 32'h0000_0001, RESP_OKAY);
		bus(0, IRQ_STAT_ADDR, 32'h0000_0000, RESP_OKAY);
		bus(0, IRQ_CLR_ADDR, 32'h0000_0000, RESP_OKAY);
		$display("test interrupt done");
		bus(1, CFG_ADDR, {21'h0, 7'h08, 1'b0, 3'h3}, RESP_OKAY);
		rx.scn_pulse();
		wait_bit(1, 1'b1, 6, n);
		cmp_out("capture at nibble end", 1, 32'(n <= 6));
		rx.trig_set(1'b1);
		rx.trig_set(1'b0);
		bus(1, CFG_ADDR, {21'h0, 7'h08, 1'b0, 3'h4}, RESP_OKAY);
		rx.scn_pulse();
		wait_bit(1, 1'b1, 6, n);
		cmp_out("no capture at nibble end", 1, 32'(n > 6));
		rx.trig_set(1'b1);
		// the capture pulse lasts one cycle, so watch while the pin falls
		fork
			rx.trig_set(1'b0);
			wait_bit(1, 1'b1, 8, n);
		join
		cmp_out("capture on trigger fall", 1, 32'(n <= 8));
		$display("test trigger done");
		bus(1, CFG_ADDR, {21'h0, 7'h01, 1'b1, 3'h6}, RESP_OKAY);
		rx.addr_pulse(4'h3);
		wait_bit(2, 1'b1, 4, n);
		wait_bit(2, 1'b0, 80, g);
		cmp_out("slot mark length", 1, 32'(n <= 4 && g >= 29 && g <= 50));
		bus(1, CFG_ADDR, {21'h0, 7'h01, 1'b0, 3'h6}, RESP_OKAY);
		rx.addr_pulse(4'h3);
		wait_bit(2, 1'b1, 60, n);
		cmp_out("no slot mark", 1, 32'(n > 60));
		$display("test slot mark done");
		complete_run();
	end
endmodule : sent_config_and_error_mask_bench
`default_nettype wire
